// [rtl/fcs_map.vh]
/*
 fcs_map.vh: register layout, field positions, reset values and
 operand format constants of the float control/status block.
 assumes: included by bare name from rtl design files.
*/
`ifndef FCS_MAP_VH
`define FCS_MAP_VH

// control register numbers on the move-control path
`define FCS_SEL_STATUS      5'h1f
`define FCS_SEL_IDENT       5'h00
// control/status fields
`define FCS_COND_BIT        23
`define FCS_CAUSE_HI        17
`define FCS_CAUSE_LO        12
`define FCS_ENABLE_HI       11
`define FCS_ENABLE_LO       7
`define FCS_ACCRUED_HI      6
`define FCS_ACCRUED_LO      2
`define FCS_ROUND_HI        1
`define FCS_ROUND_LO        0
`define FCS_UNIMPL_BIT      5
`define FCS_WRITABLE_MASK   32'h0083_ffff
`define FCS_STATUS_RESET    32'h0000_0000
// rounding encodings
`define FCS_ROUND_NEAREST   2'h0
`define FCS_ROUND_ZERO      2'h1
`define FCS_ROUND_PLUS      2'h2
`define FCS_ROUND_MINUS     2'h3
// identification fields
`define FCS_IMPL_HI         15
`define FCS_IMPL_LO         8
`define FCS_REV_HI          7
`define FCS_REV_LO          0
// single precision
`define FCS_S_SIGN          31
`define FCS_S_EXP_HI        30
`define FCS_S_EXP_LO        23
`define FCS_S_FRAC_HI       22
`define FCS_S_BIAS          8'h7f
`define FCS_S_EXP_MAXNORM   8'hfe
// double precision
`define FCS_D_SIGN          63
`define FCS_D_EXP_HI        62
`define FCS_D_EXP_LO        52
`define FCS_D_FRAC_HI       51
`define FCS_D_BIAS          11'h3ff
// class codes
`define FCS_CLS_ZERO        3'h0
`define FCS_CLS_DENORM      3'h1
`define FCS_CLS_NORMAL      3'h2
`define FCS_CLS_INF         3'h3
`define FCS_CLS_QNAN        3'h4
`define FCS_CLS_SNAN        3'h5

`endif

// [rtl/fcs_classify.v]
/*
 fcs_classify.v: registered classifier for one single or double
 precision operand; single operands sit in the low 32 bits.
 assumes: same clock and reset as the control/status block.
*/
`timescale 1ns/100ps
`include "fcs_map.vh"

module fcs_classify
(
   input  wire        clock,
   input  wire        reset,
   input  wire        enable,
   input  wire        is_double,
   input  wire [63:0] operand,
   output reg  [2:0]  class_code,
   output reg         sign,
   output reg         hidden_bit
);

   // exponent all ones / all zeros and fraction zero decide the class
   function [2:0] classify;
      input       exp_ones;
      input       exp_zero;
      input       frac_zero;
      input       frac_msb;
      begin
         if (exp_ones && !frac_zero)
            classify = frac_msb ? `FCS_CLS_SNAN
                                : `FCS_CLS_QNAN;
         else if (exp_ones)
            classify = `FCS_CLS_INF;
         else if (exp_zero && !frac_zero)
            classify = `FCS_CLS_DENORM;
         else if (exp_zero)
            classify = `FCS_CLS_ZERO;
         else
            classify = `FCS_CLS_NORMAL;
      end
   endfunction

   wire [7:0]  s_exp  = operand[`FCS_S_EXP_HI:`FCS_S_EXP_LO];
   wire [22:0] s_frac = operand[`FCS_S_FRAC_HI:0];
   wire [10:0] d_exp  = operand[`FCS_D_EXP_HI:`FCS_D_EXP_LO];
   wire [51:0] d_frac = operand[`FCS_D_FRAC_HI:0];
   wire [2:0]  s_cls;
   wire [2:0]  d_cls;

   assign s_cls = classify(&s_exp, ~|s_exp, ~|s_frac,
                           s_frac[`FCS_S_FRAC_HI]);
   assign d_cls = classify(&d_exp, ~|d_exp, ~|d_frac,
                           d_frac[`FCS_D_FRAC_HI]);

   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         class_code <= `FCS_CLS_ZERO;
         sign       <= 1'b0;
         hidden_bit <= 1'b0;
      end
      else if (enable)
      begin
         class_code <= is_double ? d_cls : s_cls;
         sign       <= is_double ? operand[`FCS_D_SIGN]
                                 : operand[`FCS_S_SIGN];
         // denormal and zero take hidden bit zero, minimum exponent
         hidden_bit <= is_double ? |d_exp : |s_exp;
      end
   end

endmodule // fcs_classify

// [rtl/fcs_cond_sync.v]
/*
 fcs_cond_sync.v: three-stage synchroniser for a level from a pin.
 assumes: a change counts once stages two and three agree.
*/
`timescale 1ns/100ps

module fcs_cond_sync
(
   input  wire clock,
   input  wire reset,
   input  wire enable,
   input  wire pin_in,
   output reg  level
);

   reg stage1;
   reg stage2;
   reg stage3;

   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         level  <= 1'b0;
      end
      else if (enable)
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3)
            level <= stage3;
      end
   end

endmodule // fcs_cond_sync

// [rtl/fcs_control_status.v]
/*
 fcs_control_status.v: control/status and identification registers of
 the float coprocessor, with condition output, interrupt and operand
 classification.
 assumes: the integer core issues the control moves on the same clock,
 datapath reports results as one-cycle pulses; an external drain input
 may come from another domain and is synchronised.
*/
// Function
// - compare writes condition bit 23: one if true, zero if false
// - condition changes only on compare or software write of status
// - condition bit drives the coprocessor condition output continuously
// - bits 17:12 hold six cause flags, rewritten after every operation
// - several exceptions in one instruction set every matching cause flag
// - any exception sets cause and matching accrued flag together (here the unimplemented-operation cause has no accrued flag)
// - accrued flags set by results only, cleared only by software write (here a software write can also set them)
// - set cause with its enable asserts float interrupt; core traps
// - unimplemented-operation cause always interrupts, no enable bit
// - bits 1:0 pick rounding: nearest even, zero, plus, minus
// - reserved bits written zero by software, read value undefined
// - status read waits for operations to drain; exception aborts read (here only an enabled or unimplemented-operation one)
// - control write loads condition, cause, accrued, enable, rounding
// - identification: implementation 15:8, revision 7:0, top half zero
// - single: sign 31, exponent 30:23, 23-bit fraction, bias 127
// - double: sign 63, exponent 62:52, 52-bit fraction, bias 1023
// - all-ones exponent: NaN or infinity; zero exponent: denormal/zero
// - NaN signaling when fraction msb set, quiet otherwise
// - normal single exponents run 1 to 254 with hidden one
// - denormal: zero exponent, nonzero fraction, hidden bit zero
// - loads, stores and moves never touch any exception flag
`timescale 1ns/100ps
`include "fcs_map.vh"

module fcs_control_status
(
   input  wire        CLOCK,
   input  wire        RESET,
   input  wire        CLOCK_ENABLE,
   // control moves from the integer core
   input  wire        CTRL_READ,
   input  wire        CTRL_WRITE,
   input  wire [4:0]  CTRL_SELECT,
   input  wire [31:0] CTRL_WDATA,
   output reg  [31:0] CTRL_RDATA,
   output reg         CTRL_RDATA_VALID,
   output reg         CTRL_READ_ABORT,
   // datapath handshake
   input  wire        OP_START,
   input  wire        OP_IS_COMPARE,
   input  wire        OP_DONE,
   input  wire        OP_COND_RESULT,
   input  wire [5:0]  OP_EXCEPTIONS,
   input  wire        PIPE_BUSY_PIN,
   output reg  [1:0]  OP_ROUNDING,
   // operand classification
   input  wire        OPERAND_VALID,
   input  wire        OPERAND_DOUBLE,
   input  wire [63:0] OPERAND,
   output reg  [2:0]  OPERAND_CLASS,
   output reg         OPERAND_SIGN,
   output reg         OPERAND_HIDDEN,
   // to the integer core
   output reg         COPROC_CONDITION_OUT,
   output reg         FLOAT_INTERRUPT,
   output reg         COPROC_INTERRUPT_N,
   output reg         ROUND_NEAREST_EVEN,
   output reg         ROUND_TOWARD_ZERO,
   output reg         ROUND_TOWARD_PLUS,
   output reg         ROUND_TOWARD_MINUS
);

   // arbitrary codes, not tied to any real part
   parameter [7:0] IMPL_CODE = 8'h5a;
   parameter [7:0] REV_CODE  = 8'h01;

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_DRAIN = 2'h1;
   localparam [1:0] ST_ANSW  = 2'h2;

   reg         condition;
   reg  [5:0]  cause;
   reg  [4:0]  trap_enable;
   reg  [4:0]  accrued;
   reg  [1:0]  rounding_select;
   reg  [1:0]  state;
   reg  [4:0]  read_select;
   reg  [3:0]  ops_pending;
   reg  [1:0]  next_state;
   reg  [3:0]  next_pending;
   wire        drain_busy;
   wire [2:0]  class_code;
   wire        class_sign;
   wire        class_hidden;

   // assembled status word; reserved bits read zero
   function [31:0] status_word;
      input       c;
      input [5:0] ca;
      input [4:0] en;
      input [4:0] ac;
      input [1:0] rm;
      begin
         status_word = 32'h0000_0000;
         status_word[`FCS_COND_BIT] = c;
         status_word[`FCS_CAUSE_HI:`FCS_CAUSE_LO] = ca;
         status_word[`FCS_ENABLE_HI:`FCS_ENABLE_LO] = en;
         status_word[`FCS_ACCRUED_HI:`FCS_ACCRUED_LO] = ac;
         status_word[`FCS_ROUND_HI:`FCS_ROUND_LO] = rm;
      end
   endfunction

   fcs_cond_sync u_busy_sync
   (
      .clock  (CLOCK),
      .reset  (RESET),
      .enable (CLOCK_ENABLE),
      .pin_in (PIPE_BUSY_PIN),
      .level  (drain_busy)
   );

   fcs_classify u_classify
   (
      .clock      (CLOCK),
      .reset      (RESET),
      .enable     (CLOCK_ENABLE && OPERAND_VALID),
      .is_double  (OPERAND_DOUBLE),
      .operand    (OPERAND),
      .class_code (class_code),
      .sign       (class_sign),
      .hidden_bit (class_hidden)
   );

   wire status_wr = CTRL_WRITE && CTRL_SELECT == `FCS_SEL_STATUS;
   wire any_trap  = cause[`FCS_UNIMPL_BIT] ||
                    |(cause[4:0] & trap_enable);

   // count of operations started and not finished
   always @*
   begin
      next_pending = ops_pending;
      if (OP_START && !OP_DONE)
         next_pending = ops_pending + 4'h1;
      else if (OP_DONE && !OP_START && ops_pending != 4'h0)
         next_pending = ops_pending - 4'h1;
   end

   // status read holds until the pipeline is empty
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (CTRL_READ)
               next_state = (CTRL_SELECT == `FCS_SEL_STATUS)
                            ? ST_DRAIN : ST_ANSW;
         ST_DRAIN:
            if (OP_DONE && OP_EXCEPTIONS != 6'h00 &&
                (OP_EXCEPTIONS[`FCS_UNIMPL_BIT] ||
                 |(OP_EXCEPTIONS[4:0] & trap_enable)))
               next_state = ST_IDLE;
            else if (next_pending == 4'h0 && !drain_busy)
               next_state = ST_ANSW;
         ST_ANSW:
            next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         condition            <= 1'b0;
         cause                <= 6'h00;
         trap_enable          <= 5'h00;
         accrued              <= 5'h00;
         rounding_select      <= `FCS_ROUND_NEAREST;
         state                <= ST_IDLE;
         read_select          <= 5'h00;
         ops_pending          <= 4'h0;
         CTRL_RDATA           <= 32'h0000_0000;
         CTRL_RDATA_VALID     <= 1'b0;
         CTRL_READ_ABORT      <= 1'b0;
         OP_ROUNDING          <= `FCS_ROUND_NEAREST;
         OPERAND_CLASS        <= `FCS_CLS_ZERO;
         OPERAND_SIGN         <= 1'b0;
         OPERAND_HIDDEN       <= 1'b0;
         COPROC_CONDITION_OUT <= 1'b0;
         FLOAT_INTERRUPT      <= 1'b0;
         COPROC_INTERRUPT_N   <= 1'b1;
         ROUND_NEAREST_EVEN   <= 1'b1;
         ROUND_TOWARD_ZERO    <= 1'b0;
         ROUND_TOWARD_PLUS    <= 1'b0;
         ROUND_TOWARD_MINUS   <= 1'b0;
      end
      else if (CLOCK_ENABLE)
      begin
         state       <= next_state;
         ops_pending <= next_pending;
         if (state == ST_IDLE && CTRL_READ)
            read_select <= CTRL_SELECT;
         // software write loads every writable field
         if (status_wr)
         begin
            condition       <= CTRL_WDATA[`FCS_COND_BIT];
            cause           <= CTRL_WDATA[`FCS_CAUSE_HI:`FCS_CAUSE_LO];
            trap_enable     <= CTRL_WDATA[`FCS_ENABLE_HI:`FCS_ENABLE_LO];
            accrued         <= CTRL_WDATA[`FCS_ACCRUED_HI:`FCS_ACCRUED_LO];
            rounding_select <= CTRL_WDATA[`FCS_ROUND_HI:`FCS_ROUND_LO];
         end
         // writes are only legal when idle, so a result never collides
         else if (OP_DONE)
         begin
            if (OP_IS_COMPARE)
               condition <= OP_COND_RESULT;
            cause   <= OP_EXCEPTIONS;
            accrued <= accrued | OP_EXCEPTIONS[4:0];
         end
         // loads, stores, moves never reach OP_DONE here
         if (OP_START)
            OP_ROUNDING <= rounding_select;
         CTRL_RDATA_VALID <= (state == ST_ANSW);
         CTRL_READ_ABORT  <= (state == ST_DRAIN && next_state == ST_IDLE);
         if (state == ST_ANSW)
         begin
            if (read_select == `FCS_SEL_STATUS)
               CTRL_RDATA <= status_word(condition, cause, trap_enable,
                                         accrued, rounding_select);
            else if (read_select == `FCS_SEL_IDENT)
               CTRL_RDATA <= {16'h0000, IMPL_CODE, REV_CODE};
            else
               CTRL_RDATA <= 32'h0000_0000;
         end
         OPERAND_CLASS        <= class_code;
         OPERAND_SIGN         <= class_sign;
         OPERAND_HIDDEN       <= class_hidden;
         COPROC_CONDITION_OUT <= condition;
         FLOAT_INTERRUPT      <= any_trap;
         COPROC_INTERRUPT_N   <= ~any_trap;
         ROUND_NEAREST_EVEN   <= rounding_select == `FCS_ROUND_NEAREST;
         ROUND_TOWARD_ZERO    <= rounding_select == `FCS_ROUND_ZERO;
         ROUND_TOWARD_PLUS    <= rounding_select == `FCS_ROUND_PLUS;
         ROUND_TOWARD_MINUS   <= rounding_select == `FCS_ROUND_MINUS;
      end
   end

endmodule // fcs_control_status

// [tb/fcs_control_status_properties.sv]
/*
 fcs_control_status_properties.sv: port checker for the float status block.
 assumes: single clock, async reset, bound onto every design instance.
*/
`timescale 1ns/100ps
module fcs_control_status_properties
#(
   parameter [7:0] IMPL_CODE = 8'h5a,
   parameter [7:0] REV_CODE  = 8'h01
)
(
   input wire        CLOCK,
   input wire        RESET,
   input wire        CTRL_READ,
   input wire        CTRL_WRITE,
   input wire [4:0]  CTRL_SELECT,
   input wire [31:0] CTRL_WDATA,
   input wire [31:0] CTRL_RDATA,
   input wire        CTRL_RDATA_VALID,
   input wire        CTRL_READ_ABORT,
   input wire        OP_DONE,
   input wire        OP_IS_COMPARE,
   input wire        OP_COND_RESULT,
   input wire [5:0]  OP_EXCEPTIONS,
   input wire        COPROC_CONDITION_OUT,
   input wire        FLOAT_INTERRUPT,
   input wire        COPROC_INTERRUPT_N,
   input wire        ROUND_NEAREST_EVEN,
   input wire        ROUND_TOWARD_ZERO,
   input wire        ROUND_TOWARD_PLUS,
   input wire        ROUND_TOWARD_MINUS
);
   reg rd_busy;
   wire quiet = !(OP_DONE && OP_IS_COMPARE) && !CTRL_WRITE;
   // reads that overlap are ignored, so only idle reads arm a check
   always @(posedge CLOCK or posedge RESET)
      if (RESET)
         rd_busy <= 1'b0;
      else
         rd_busy <= (rd_busy & ~(CTRL_RDATA_VALID | CTRL_READ_ABORT))
                    | (CTRL_READ & ~rd_busy);
   function automatic logic irq_of(input logic [31:0] w);
      irq_of = |(w[17:12] & {1'b1, w[11:7]});
   endfunction
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   sequence s_cmp_done;
      OP_DONE && OP_IS_COMPARE && !CTRL_WRITE;
   endsequence
   sequence s_stat_write;
      CTRL_WRITE && CTRL_SELECT == 5'h1f ##1 !CTRL_WRITE && !OP_DONE;
   endsequence
   a_cond_compare:
      assert property (s_cmp_done |-> ##2
         COPROC_CONDITION_OUT == $past(OP_COND_RESULT, 2))
      else $error("condition output misses compare result");
   a_cond_hold:
      assert property (quiet |-> ##2
         COPROC_CONDITION_OUT == $past(COPROC_CONDITION_OUT))
      else $error("condition output moved without cause");
   a_write_cond:
      assert property (s_stat_write |->
         ##1 COPROC_CONDITION_OUT == $past(CTRL_WDATA[23], 2))
      else $error("condition output misses written bit");
   a_write_irq:
      assert property (s_stat_write |=>
         FLOAT_INTERRUPT == irq_of($past(CTRL_WDATA, 2)))
      else $error("interrupt level wrong after write");
   a_unimpl_trap:
      assert property (OP_DONE && OP_EXCEPTIONS[5] && !CTRL_WRITE
         |-> ##[1:2] FLOAT_INTERRUPT)
      else $error("unimplemented operation did not interrupt");
   a_irq_pair:
      assert property (FLOAT_INTERRUPT != COPROC_INTERRUPT_N)
      else $error("interrupt outputs not complementary");
   a_round_write:
      assert property (s_stat_write |=> {ROUND_TOWARD_MINUS,
         ROUND_TOWARD_PLUS, ROUND_TOWARD_ZERO, ROUND_NEAREST_EVEN}
         == (4'h1 << $past(CTRL_WDATA[1:0], 2)))
      else $error("rounding decode wrong after write");
   a_ident_read:
      assert property (CTRL_READ && CTRL_SELECT == 5'h00 && !rd_busy
         |-> ##2 CTRL_RDATA_VALID
         && CTRL_RDATA == {16'h0000, IMPL_CODE, REV_CODE})
      else $error("identification read wrong");
   a_valid_pulse:
      assert property (CTRL_RDATA_VALID |=>
         !CTRL_RDATA_VALID && !CTRL_READ_ABORT)
      else $error("read answer longer than one cycle");
endmodule // fcs_control_status_properties

bind fcs_control_status fcs_control_status_properties
   #(.IMPL_CODE(IMPL_CODE), .REV_CODE(REV_CODE)) chk
   (.CLOCK(CLOCK), .RESET(RESET), .CTRL_READ(CTRL_READ),
    .CTRL_WRITE(CTRL_WRITE), .CTRL_SELECT(CTRL_SELECT),
    .CTRL_WDATA(CTRL_WDATA), .CTRL_RDATA(CTRL_RDATA),
    .CTRL_RDATA_VALID(CTRL_RDATA_VALID), .CTRL_READ_ABORT(CTRL_READ_ABORT),
    .OP_DONE(OP_DONE), .OP_IS_COMPARE(OP_IS_COMPARE),
    .OP_COND_RESULT(OP_COND_RESULT), .OP_EXCEPTIONS(OP_EXCEPTIONS),
    .COPROC_CONDITION_OUT(COPROC_CONDITION_OUT),
    .FLOAT_INTERRUPT(FLOAT_INTERRUPT), .COPROC_INTERRUPT_N(COPROC_INTERRUPT_N),
    .ROUND_NEAREST_EVEN(ROUND_NEAREST_EVEN),
    .ROUND_TOWARD_ZERO(ROUND_TOWARD_ZERO),
    .ROUND_TOWARD_PLUS(ROUND_TOWARD_PLUS),
    .ROUND_TOWARD_MINUS(ROUND_TOWARD_MINUS));

// [tb/fcs_core_model.sv]
/*
 fcs_core_model.sv: integer core side, issuing control moves.
 assumes: same clock as the block; the bench calls its tasks.
*/
`timescale 1ns/100ps
module fcs_core_model
(
   input  wire        clock,
   input  wire        valid,
   input  wire        abort,
   input  wire        irq,
   input  wire [31:0] rdata,
   output reg         rd = 1'b0,
   output reg         wr = 1'b0,
   output reg  [4:0]  sel = 5'h00,
   output reg  [31:0] wdata = 32'h0000_0000
);
   integer traps = 0;
   reg     irq_q = 1'b0;
   // one interrupt exception per rising request
   always @(posedge clock)
   begin
      irq_q <= irq;
      if (irq && !irq_q)
         traps <= traps + 1;
   end
   // st: 1 answered, 2 dropped, 0 no answer in time
   task cread(input [4:0] s, output [31:0] d, output integer st);
      integer n;
      st = 0;
      @(posedge clock);
      rd <= 1'b1;
      sel <= s;
      @(posedge clock);
      rd <= 1'b0;
      for (n = 0; n < 40 && st == 0; n = n + 1)
      begin
         @(posedge clock);
         d = rdata;
         st = valid ? 1 : abort ? 2 : 0;
      end
   endtask
   // bench calls this only with no operation in flight
   task cwrite(input [4:0] s, input [31:0] v);
      @(posedge clock);
      wr <= 1'b1;
      sel <= s;
      wdata <= v & 32'h0083_ffff;
      @(posedge clock);
      wr <= 1'b0;
      wdata <= ~(v & 32'h0083_ffff);
   endtask
endmodule // fcs_core_model

// [tb/test_fcs_control_status.sv]
/*
 test_fcs_control_status.sv: self-checking bench for the status block.
 assumes: rtl files and the checker compiled first.
*/
`timescale 1ns/100ps
module test_fcs_control_status;
   reg         clock = 1'b0, reset = 1'b1, op_start = 1'b0, op_cmp = 1'b0;
   reg         op_done = 1'b0, op_res = 1'b0, opv = 1'b0, opd = 1'b0;
   reg  [5:0]  op_exc = 6'h00;
   reg         busy = 1'b0;
   reg  [63:0] operand = 64'h0000_0000_0000_0000;
   wire [31:0] rdata, wdata;
   wire [4:0]  sel;
   wire [2:0]  cls;
   wire [1:0]  op_rm;
   wire        valid, abort, rd, wr, sgn, hid, cond, irq, irq_n;
   wire        rne, rtz, rtp, rtm;
   integer     miscompares = 0, total_checks = 0, st, i, t;
   reg  [31:0] d;
   // {double, operand, class, sign, hidden}
   reg  [69:0] row [0:12] = '{
      {1'b0, 64'hffff_ffff_0000_0000, 3'h0, 1'b0, 1'b0},
      {1'b0, 64'h0000_0000_8000_0000, 3'h0, 1'b1, 1'b0},
      {1'b0, 64'h0000_0000_0000_0001, 3'h1, 1'b0, 1'b0},
      {1'b0, 64'h0000_0000_8080_0000, 3'h2, 1'b1, 1'b1},
      {1'b0, 64'h0000_0000_7f7f_ffff, 3'h2, 1'b0, 1'b1},
      {1'b0, 64'h0000_0000_ff80_0000, 3'h3, 1'b1, 1'b0},
      {1'b0, 64'h0000_0000_7fc0_0000, 3'h5, 1'b0, 1'b0},
      {1'b0, 64'h0000_0000_7f80_0001, 3'h4, 1'b0, 1'b0},
      {1'b1, 64'h3ff0_0000_0000_0000, 3'h2, 1'b0, 1'b1},
      {1'b1, 64'h8000_0000_0000_0001, 3'h1, 1'b1, 1'b0},
      {1'b1, 64'h7ff0_0000_0000_0000, 3'h3, 1'b0, 1'b0},
      {1'b1, 64'hfff8_0000_0000_0000, 3'h5, 1'b1, 1'b0},
      {1'b1, 64'h7ff0_0000_0000_0001, 3'h4, 1'b0, 1'b0}};

   always #4 clock = ~clock;

   // identity values are arbitrary
   fcs_control_status #(.IMPL_CODE(8'h5a), .REV_CODE(8'h01)) uut
   (.CLOCK(clock), .RESET(reset), .CLOCK_ENABLE(1'b1), .CTRL_READ(rd),
    .CTRL_WRITE(wr), .CTRL_SELECT(sel), .CTRL_WDATA(wdata),
    .CTRL_RDATA(rdata), .CTRL_RDATA_VALID(valid), .CTRL_READ_ABORT(abort),
    .OP_START(op_start), .OP_IS_COMPARE(op_cmp), .OP_DONE(op_done),
    .OP_COND_RESULT(op_res), .OP_EXCEPTIONS(op_exc), .PIPE_BUSY_PIN(busy),
    .OP_ROUNDING(op_rm), .OPERAND_VALID(opv), .OPERAND_DOUBLE(opd),
    .OPERAND(operand), .OPERAND_CLASS(cls), .OPERAND_SIGN(sgn),
    .OPERAND_HIDDEN(hid), .COPROC_CONDITION_OUT(cond),
    .FLOAT_INTERRUPT(irq), .COPROC_INTERRUPT_N(irq_n),
    .ROUND_NEAREST_EVEN(rne), .ROUND_TOWARD_ZERO(rtz),
    .ROUND_TOWARD_PLUS(rtp), .ROUND_TOWARD_MINUS(rtm));

   fcs_core_model core
   (.clock(clock), .valid(valid), .abort(abort), .irq(irq), .rdata(rdata),
    .rd(rd), .wr(wr), .sel(sel), .wdata(wdata));

   task chk(input string nm, input [63:0] seen, input [63:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task report_and_stop;
      if (miscompares == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // a read with no answer in time ends the run at once; a dropped one does not
   task rdc(input [4:0] s, input [31:0] e);
      core.cread(s, d, st);
      chk("read answer", st, 1);
      if (st == 0)
         report_and_stop;
      chk("read data", d, e);
   endtask
   task wrs(input [31:0] v);
      core.cwrite(5'h1f, v);
      repeat (2) @(posedge clock);
      #1;
   endtask
   task op(input c, input r, input [5:0] x, input integer w);
      @(posedge clock);
      op_start <= 1'b1;
      @(posedge clock);
      op_start <= 1'b0;
      repeat (w) @(posedge clock);
      op_done <= 1'b1;
      op_cmp <= c;
      op_res <= r;
      op_exc <= x;
      @(posedge clock);
      op_done <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
   endtask

   initial
   begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      #1;
      chk("reset outs", {rne, rtz, rtp, rtm, irq_n, irq, cond}, 7'h44);
      rdc(5'h1f, 32'h0000_0000);
      rdc(5'h00, {16'h0000, 8'h5a, 8'h01});
      for (i = 0; i < 13; i = i + 1)
      begin
         @(posedge clock);
         opv <= 1'b1;
         opd <= row[i][69];
         operand <= row[i][68:5];
         @(posedge clock);
         opv <= 1'b0;
         repeat (2) @(posedge clock);
         #1;
         chk("class sign", {cls, sgn}, row[i][4:1]);
         if (row[i][4:2] < 3'h3)
            chk("hidden", hid, row[i][0]);
      end
      for (i = 0; i < 4; i = i + 1)
      begin
         wrs({30'h0, i[1:0]});
         chk("round", {rtm, rtp, rtz, rne}, 4'h1 << i);
         op(1'b0, 1'b0, 6'h00, 0);
         chk("op round", op_rm, i[1:0]);
      end
      op(1'b1, 1'b1, 6'h00, 0);
      chk("cond", cond, 1);
      rdc(5'h1f, 32'h0080_0003);
      op(1'b0, 1'b0, 6'h00, 0);
      chk("cond kept", cond, 1);
      op(1'b1, 1'b0, 6'h00, 0);
      chk("cond clear", cond, 0);
      wrs(32'h0000_0000);
      op(1'b0, 1'b0, 6'h03, 0);
      rdc(5'h1f, 32'h0000_300c);
      op(1'b0, 1'b0, 6'h08, 0);
      rdc(5'h1f, 32'h0000_802c);
      op(1'b1, 1'b1, 6'h00, 0);
      rdc(5'h1f, 32'h0080_002c);
      chk("masked irq", irq, 0);
      wrs(32'hffff_ffff);
      chk("all set", {cond, irq, irq_n}, 3'h6);
      rdc(5'h1f, 32'h0083_ffff);
      wrs(32'h0000_0400);
      rdc(5'h1f, 32'h0000_0400);
      t = core.traps;
      op(1'b0, 1'b0, 6'h08, 0);
      chk("irq", {irq, irq_n}, 2'h2);
      chk("traps", core.traps - t, 1);
      op(1'b0, 1'b0, 6'h01, 0);
      chk("irq off", irq, 0);
      op(1'b0, 1'b0, 6'h20, 0);
      chk("unimpl irq", irq, 1);
      wrs(32'h0000_8000);
      fork
         op(1'b0, 1'b0, 6'h00, 3);
         core.cread(5'h1f, d, st);
      join
      chk("drained", {st[1:0], d}, {2'h1, 32'h0000_0000});
      wrs(32'h0000_0400);
      fork
         op(1'b0, 1'b0, 6'h08, 3);
         core.cread(5'h1f, d, st);
      join
      chk("aborted", st, 2);
      rdc(5'h1f, 32'h0000_8420);
      // busy pin holds the read until it has been low through the sync
      @(posedge clock);
      busy <= 1'b1;
      repeat (4) @(posedge clock);
      fork
         begin
            repeat (12) @(posedge clock);
            chk("busy held", valid, 0);
            busy <= 1'b0;
         end
         core.cread(5'h1f, d, st);
      join
      chk("busy drained", {st[1:0], d}, {2'h1, 32'h0000_8420});
      // reset in mid-run returns every field to its reset value
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      #1;
      chk("rerun outs", {rne, rtz, rtp, rtm, irq_n, irq, cond}, 7'h44);
      rdc(5'h1f, 32'h0000_0000);
      report_and_stop;
   end
endmodule // test_fcs_control_status
